// file: verilog/pif_flags.sv
// Peripheral interrupt request flags, enables and core request
`timescale 1ns/1ps
`default_nettype none
module pif_flags
	import pif_pkg::*;
#(
	parameter int PIN_FLAGS = 12
) (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_sys_rst,
	// Register port
	input  wire logic [11:0]          i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [7:0]           o_rdata,
	// Peripheral events and levels
	input  wire pif_events_s          i_events,
	input  wire logic                 i_ext_pin,
	input  wire logic [PIN_FLAGS-1:0] i_per_pin_change_flags,
	input  wire logic                 i_serial_rx_ready,
	input  wire logic                 i_serial_tx_empty,
	// Core side
	output logic                      o_core_irq_req,
	output logic                      o_wake_req
);

	// ============================================================
	// State
	logic [7:0] ctrl_reg;
	logic [7:0] req0_reg;
	logic [7:0] req1_reg;
	logic [7:0] req2_reg;
	logic [7:0] en0_reg;
	logic [7:0] en1_reg;
	logic [7:0] en2_reg;
	logic [7:0] rdata_reg;
	logic       pin_prev_reg;
	logic       pin_valid_reg;

	// ============================================================
	// Address decode
	wire wr_ctrl = i_wr && (i_addr == PIF_OFS_CONTROL);
	wire wr_req0 = i_wr && (i_addr == PIF_OFS_REQ0);
	wire wr_req1 = i_wr && (i_addr == PIF_OFS_REQ1);
	wire wr_req2 = i_wr && (i_addr == PIF_OFS_REQ2);
	wire wr_en0  = i_wr && (i_addr == PIF_OFS_EN0);
	wire wr_en1  = i_wr && (i_addr == PIF_OFS_EN1);
	wire wr_en2  = i_wr && (i_addr == PIF_OFS_EN2);

	// ============================================================
	// External edge detect; first sample after reset is not an edge
	wire edge_rise = i_ext_pin && !pin_prev_reg;
	wire edge_fall = !i_ext_pin && pin_prev_reg;
	wire ext_edge  = pin_valid_reg &&
		(ctrl_reg[PIF_B_EDGE_SEL] ? edge_rise : edge_fall);

	// ============================================================
	// Hardware set vectors, enables not involved
	logic [7:0] set0;
	logic [7:0] set1;
	logic [7:0] set2;
	always_comb begin
		set0 = PIF_RST_ZERO;
		set1 = PIF_RST_ZERO;
		set2 = PIF_RST_ZERO;
		set0[PIF_B_TIMER0]   = i_events.timer0_overflow;
		set0[PIF_B_EXTEDGE]  = ext_edge;
		set1[PIF_B_CAPT1]    = i_events.capture1;
		set1[PIF_B_TIMER2]   = i_events.timer2;
		set1[PIF_B_TIMER1]   = i_events.timer1;
		set1[PIF_B_COLLIDE]  = i_events.bus_collision;
		set1[PIF_B_SYNCPORT] = i_events.sync_port;
		set1[PIF_B_CONVERT]  = i_events.converter;
		set2[PIF_B_CAPT2]    = i_events.capture2;
		set2[PIF_B_NVMDONE]  = i_events.nvm_done;
		set2[PIF_B_T1GATE]   = i_events.timer1_gate;
	end

	// ============================================================
	// Sticky update: a write replaces, but a same-cycle event still wins
	function automatic logic [7:0] sticky(
		input logic [7:0] cur,
		input logic [7:0] wd,
		input logic       wen,
		input logic [7:0] wm,
		input logic [7:0] hs
	);
		logic [7:0] base;
		base = wen ? wd : cur;
		return (base | hs) & wm;
	endfunction

	wire [7:0] req0_next = sticky(req0_reg, i_wdata, wr_req0,
		PIF_WM_REQ0, set0);
	wire [7:0] req1_next = sticky(req1_reg, i_wdata, wr_req1,
		PIF_WM_REQ1, set1);
	wire [7:0] req2_next = sticky(req2_reg, i_wdata, wr_req2,
		PIF_WM_REQ2, set2);

	// ============================================================
	// Read-only live bits overlaid on the stored flags
	logic [7:0] req0_view;
	logic [7:0] req1_view;
	always_comb begin
		req0_view = req0_reg;
		req1_view = req1_reg;
		req0_view[PIF_B_PINCHG]  = |i_per_pin_change_flags;
		req1_view[PIF_B_RXREADY] = i_serial_rx_ready;
		req1_view[PIF_B_TXEMPTY] = i_serial_tx_empty;
	end

	// ============================================================
	// Read mux; unmapped addresses answer zero
	wire [7:0] rd_mux =
		(i_addr == PIF_OFS_CONTROL) ? ctrl_reg  :
		(i_addr == PIF_OFS_REQ0)    ? req0_view :
		(i_addr == PIF_OFS_REQ1)    ? req1_view :
		(i_addr == PIF_OFS_REQ2)    ? req2_reg  :
		(i_addr == PIF_OFS_EN0)     ? en0_reg   :
		(i_addr == PIF_OFS_EN1)     ? en1_reg   :
		(i_addr == PIF_OFS_EN2)     ? en2_reg   : PIF_RST_ZERO;

	// ============================================================
	// Request qualification
	wire global_irq_enable  = ctrl_reg[PIF_B_GLOBAL];
	wire peripheral_group_enable = ctrl_reg[PIF_B_PGROUP];
	wire grp0 = |(req0_view & en0_reg);
	wire grp1 = |(req1_view & en1_reg) |
		|(req2_reg & en2_reg);
	// Wake ignores the gates, as a sleeping core still needs waking
	assign o_wake_req     = grp0 | grp1;
	assign o_core_irq_req = global_irq_enable & (grp0 | (peripheral_group_enable & grp1));
	assign o_rdata        = rdata_reg;

	// ============================================================
	// Flag registers
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			req0_reg <= PIF_RST_ZERO;
			req1_reg <= PIF_RST_ZERO;
			req2_reg <= PIF_RST_ZERO;
		end else begin
			req0_reg <= req0_next;
			req1_reg <= req1_next;
			req2_reg <= req2_next;
		end
	end

	// ============================================================
	// Control and enable registers
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_reg <= PIF_RST_CONTROL;
			en0_reg  <= PIF_RST_ZERO;
			en1_reg  <= PIF_RST_ZERO;
			en2_reg  <= PIF_RST_ZERO;
		end else begin
			if (wr_ctrl) ctrl_reg <= i_wdata & PIF_WM_CONTROL;
			if (wr_en0)  en0_reg  <= i_wdata & PIF_WM_EN0;
			if (wr_en1)  en1_reg  <= i_wdata & PIF_WM_EN1;
			if (wr_en2)  en2_reg  <= i_wdata & PIF_WM_EN2;
		end
	end

	// ============================================================
	// Read data and pin history
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_reg     <= PIF_RST_ZERO;
			pin_prev_reg  <= 1'b0;
			pin_valid_reg <= 1'b0;
		end else begin
			rdata_reg     <= i_rd ? rd_mux : PIF_RST_ZERO;
			pin_prev_reg  <= i_ext_pin;
			pin_valid_reg <= 1'b1;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	property p_t0_set;
		i_events.timer0_overflow |=> req0_reg[PIF_B_TIMER0];
	endproperty
	a_t0_set: assert property (p_t0_set)
		else $error("timer0 flag not set");

	property p_conv_poll;
		(i_events.converter && en1_reg == 8'h00 && !global_irq_enable)
			|=> req1_reg[PIF_B_CONVERT];
	endproperty
	a_conv_poll: assert property (p_conv_poll)
		else $error("flag needs enable to set");

	property p_pinchg;
		(i_rd && i_addr == PIF_OFS_REQ0)
			|=> o_rdata[PIF_B_PINCHG] == $past(|i_per_pin_change_flags);
	endproperty
	a_pinchg: assert property (p_pinchg)
		else $error("pin change summary wrong");

	property p_rxready;
		(i_rd && i_addr == PIF_OFS_REQ1)
			|=> o_rdata[PIF_B_RXREADY] == $past(i_serial_rx_ready);
	endproperty
	a_rxready: assert property (p_rxready)
		else $error("rx ready bit wrong");

	property p_ext_rise;
		(pin_valid_reg && !pin_prev_reg && i_ext_pin &&
			ctrl_reg[PIF_B_EDGE_SEL]) |=> req0_reg[PIF_B_EXTEDGE];
	endproperty
	a_ext_rise: assert property (p_ext_rise)
		else $error("external edge missed");

	property p_collide_hold;
		(req1_reg[PIF_B_COLLIDE] && !wr_req1)
			|=> req1_reg[PIF_B_COLLIDE];
	endproperty
	a_collide_hold: assert property (p_collide_hold)
		else $error("collision flag dropped");

	property p_gate_set;
		i_events.timer1_gate |=> req2_reg[PIF_B_T1GATE];
	endproperty
	a_gate_set: assert property (p_gate_set)
		else $error("gate flag not set");

	property p_global;
		!global_irq_enable |-> !o_core_irq_req;
	endproperty
	a_global: assert property (p_global)
		else $error("request without global enable");

	property p_pgroup;
		(!peripheral_group_enable && !grp0) |-> !o_core_irq_req;
	endproperty
	a_pgroup: assert property (p_pgroup)
		else $error("group request without group enable");

	property p_first_grp;
		(global_irq_enable && i_events.timer0_overflow && en0_reg[PIF_B_TIMER0] &&
			!wr_ctrl && !wr_en0) |=> o_core_irq_req;
	endproperty
	a_first_grp: assert property (p_first_grp)
		else $error("first group request missing");

	property p_en2_write;
		wr_en2 |=> en2_reg == ($past(i_wdata) & PIF_WM_EN2);
	endproperty
	a_en2_write: assert property (p_en2_write)
		else $error("enable 2 write lost");

	// Every hardware event lands in its flag one cycle later
	property p_capt1_set;
		i_events.capture1 |=> req1_reg[PIF_B_CAPT1];
	endproperty
	a_capt1_set: assert property (p_capt1_set)
		else $error("capture 1 flag not set");

	property p_timer2_set;
		i_events.timer2 |=> req1_reg[PIF_B_TIMER2];
	endproperty
	a_timer2_set: assert property (p_timer2_set)
		else $error("timer2 flag not set");

	property p_timer1_set;
		i_events.timer1 |=> req1_reg[PIF_B_TIMER1];
	endproperty
	a_timer1_set: assert property (p_timer1_set)
		else $error("timer1 flag not set");

	property p_sync_set;
		i_events.sync_port |=> req1_reg[PIF_B_SYNCPORT];
	endproperty
	a_sync_set: assert property (p_sync_set)
		else $error("sync port flag not set");

	property p_collide_set;
		i_events.bus_collision |=> req1_reg[PIF_B_COLLIDE];
	endproperty
	a_collide_set: assert property (p_collide_set)
		else $error("collision flag not set");

	property p_capt2_set;
		i_events.capture2 |=> req2_reg[PIF_B_CAPT2];
	endproperty
	a_capt2_set: assert property (p_capt2_set)
		else $error("capture 2 flag not set");

	property p_nvm_set;
		i_events.nvm_done |=> req2_reg[PIF_B_NVMDONE];
	endproperty
	a_nvm_set: assert property (p_nvm_set)
		else $error("nvm done flag not set");

	// Flags hold until software writes their register
	property p_t0_hold;
		(req0_reg[PIF_B_TIMER0] && !wr_req0) |=> req0_reg[PIF_B_TIMER0];
	endproperty
	a_t0_hold: assert property (p_t0_hold)
		else $error("timer0 flag dropped");

	property p_t0_clear;
		(wr_req0 && !i_wdata[PIF_B_TIMER0] && !i_events.timer0_overflow)
			|=> !req0_reg[PIF_B_TIMER0];
	endproperty
	a_t0_clear: assert property (p_t0_clear)
		else $error("timer0 flag not cleared");

	property p_capt1_hold;
		(req1_reg[PIF_B_CAPT1] && !wr_req1)
			|=> req1_reg[PIF_B_CAPT1];
	endproperty
	a_capt1_hold: assert property (p_capt1_hold)
		else $error("capture 1 flag dropped");

	property p_conv_hold;
		(req1_reg[PIF_B_CONVERT] && !wr_req1)
			|=> req1_reg[PIF_B_CONVERT];
	endproperty
	a_conv_hold: assert property (p_conv_hold)
		else $error("converter flag dropped");

	property p_capt2_hold;
		(req2_reg[PIF_B_CAPT2] && !wr_req2)
			|=> req2_reg[PIF_B_CAPT2];
	endproperty
	a_capt2_hold: assert property (p_capt2_hold)
		else $error("capture 2 flag dropped");

	property p_nvm_hold;
		(req2_reg[PIF_B_NVMDONE] && !wr_req2)
			|=> req2_reg[PIF_B_NVMDONE];
	endproperty
	a_nvm_hold: assert property (p_nvm_hold)
		else $error("nvm done flag dropped");

	property p_gate_hold;
		(req2_reg[PIF_B_T1GATE] && !wr_req2)
			|=> req2_reg[PIF_B_T1GATE];
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gate flag dropped");

	// Live bits read back as they stood when the read was taken; a selected falling external edge sets its flag
	property p_txempty;
		(i_rd && i_addr == PIF_OFS_REQ1)
			|=> o_rdata[PIF_B_TXEMPTY] == $past(i_serial_tx_empty);
	endproperty
	a_txempty: assert property (p_txempty)
		else $error("tx empty bit wrong");

	property p_ext_fall;
		(pin_valid_reg && pin_prev_reg && !i_ext_pin &&
			!ctrl_reg[PIF_B_EDGE_SEL]) |=> req0_reg[PIF_B_EXTEDGE];
	endproperty
	a_ext_fall: assert property (p_ext_fall)
		else $error("falling external edge missed");

	// Enabled pending flags must reach the core once the gates open
	property p_grp0_on;
		(global_irq_enable && |(req0_view & en0_reg))
			|-> o_core_irq_req;
	endproperty
	a_grp0_on: assert property (p_grp0_on)
		else $error("first group request not raised");

	property p_pgroup_on;
		(global_irq_enable && peripheral_group_enable && |(req2_reg & en2_reg))
			|-> o_core_irq_req;
	endproperty
	a_pgroup_on: assert property (p_pgroup_on)
		else $error("third group request not raised");

endmodule
`default_nettype wire

// file: pkg/pif_pkg.sv
// Constants, field layout and event carrier for the peripheral irq flags
// ============================================================
// Summary of operation
// - Third enable: capture2 bit 7, nvm done bit 6, timer1 gate bit 5.
// - Second and third group requests also need the peripheral group enable.
// - Flags set by hardware regardless of enables, so software can poll.
// - Request 0 bit 5 sets on timer0 overflow, stays until written zero.
// - Request 0 bit 4 is read-only OR of all per-pin change flags.
// - Request 0 bit 0 sets on selected external edge; read/write.
// - Request 1 bit 7 sets on capture unit 1 event; software clears.
// - Request 1 bits 6,5,1,0: timer2, timer1, sync port, converter events.
// - Request 1 bit 4 read-only, high while receive buffer holds a byte.
// - Request 1 bit 3 read-only, high while transmit buffer is empty.
// - Request 1 bit 2 sets on sync port bus collision; software clears.
// - Request 2 bit 7 sets on capture unit 2 event; software clears.
// - Request 2 bit 6 sets when nonvolatile memory operation completes.
// - Request 2 bit 5 sets when timer1 gate goes inactive.
// - Global enable gates the core interrupt request; wake ignores it.
// - First group needs only the global enable.
package pif_pkg;

	// ============================================================
	// Register offsets
	localparam logic [11:0] PIF_OFS_CONTROL = 12'h00b;
	localparam logic [11:0] PIF_OFS_REQ0    = 12'h70c;
	localparam logic [11:0] PIF_OFS_REQ1    = 12'h70d;
	localparam logic [11:0] PIF_OFS_REQ2    = 12'h70e;
	localparam logic [11:0] PIF_OFS_EN0     = 12'h716;
	localparam logic [11:0] PIF_OFS_EN1     = 12'h717;
	localparam logic [11:0] PIF_OFS_EN2     = 12'h718;

	// ============================================================
	// Field positions
	localparam int PIF_B_GLOBAL   = 7;
	localparam int PIF_B_PGROUP   = 6;
	localparam int PIF_B_EDGE_SEL = 0;
	localparam int PIF_B_TIMER0   = 5;
	localparam int PIF_B_PINCHG   = 4;
	localparam int PIF_B_EXTEDGE  = 0;
	localparam int PIF_B_CAPT1    = 7;
	localparam int PIF_B_TIMER2   = 6;
	localparam int PIF_B_TIMER1   = 5;
	localparam int PIF_B_RXREADY  = 4;
	localparam int PIF_B_TXEMPTY  = 3;
	localparam int PIF_B_COLLIDE  = 2;
	localparam int PIF_B_SYNCPORT = 1;
	localparam int PIF_B_CONVERT  = 0;
	localparam int PIF_B_CAPT2    = 7;
	localparam int PIF_B_NVMDONE  = 6;
	localparam int PIF_B_T1GATE   = 5;

	// ============================================================
	// Reset values and writable masks
	localparam logic [7:0] PIF_RST_CONTROL = 8'h01;
	localparam logic [7:0] PIF_RST_ZERO    = 8'h00;
	localparam logic [7:0] PIF_WM_CONTROL  = 8'hc1;
	localparam logic [7:0] PIF_WM_REQ0     = 8'h21;
	localparam logic [7:0] PIF_WM_REQ1     = 8'he7;
	localparam logic [7:0] PIF_WM_REQ2     = 8'he0;
	localparam logic [7:0] PIF_WM_EN0      = 8'h31;
	localparam logic [7:0] PIF_WM_EN1      = 8'hff;
	localparam logic [7:0] PIF_WM_EN2      = 8'he0;

	// ============================================================
	// One-cycle event pulses from the peripherals
	typedef struct packed {
		logic timer0_overflow;
		logic capture1;
		logic timer2;
		logic timer1;
		logic bus_collision;
		logic sync_port;
		logic converter;
		logic capture2;
		logic nvm_done;
		logic timer1_gate;
	} pif_events_s;

endpackage

// file: verification/pif_periph_model.sv
// Behavioural peripheral side: event pulses, pin flags, serial buffers
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model
	import pif_pkg::*;
#(
	parameter int PIN_FLAGS = 12
) (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_sys_rst,
	// Bench commands
	input  wire logic [9:0]           i_fire,
	input  wire logic [PIN_FLAGS-1:0] i_pin_set,
	input  wire logic [PIN_FLAGS-1:0] i_pin_clr,
	input  wire logic [3:0]           i_serial_cmd,
	// Toward the flag block
	output var  pif_events_s          o_events,
	output logic [PIN_FLAGS-1:0]      o_pin_flags,
	output logic                      o_rx_ready,
	output logic                      o_tx_empty
);
	// ============================================================
	// Occupancy
	logic [1:0] rx_count_reg;

	// Events are single-cycle pulses, no holding
	assign o_events   = pif_events_s'(i_fire);
	// Ready only while a byte waits; reading drops it
	assign o_rx_ready = (rx_count_reg != 2'h0);

	// Sticky pin flags and buffer state; command {push,pop,load,move}
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pin_flags  <= '0;
			rx_count_reg <= 2'h0;
			o_tx_empty   <= 1'b1;
		end else begin
			o_pin_flags  <= (o_pin_flags | i_pin_set) & ~i_pin_clr;
			rx_count_reg <= rx_count_reg + 2'(i_serial_cmd[3])
				- 2'(i_serial_cmd[2]);
			// Load fills the buffer; move to shifter empties it
			if (i_serial_cmd[1]) begin
				o_tx_empty <= 1'b0;
			end else if (i_serial_cmd[0]) begin
				o_tx_empty <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/pif_flags_tb.sv
// Self-checking bench for the peripheral irq flag block
`timescale 1ns/1ps
`default_nettype none
module pif_flags_tb
	import pif_pkg::*;
;
	logic        i_clock, i_sys_rst, wr, rd, ext, irq, wake, rx, tx;
	logic [11:0] addr, pset, pclr, pins;
	logic [7:0]  wdata, rdata;
	logic [9:0]  fire;
	logic [3:0]  scmd;
	pif_events_s ev;
	int          err_total, compares, i;

	// ============================================================
	// Design and peripheral model
	pif_flags #(.PIN_FLAGS(12)) uut (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_events(ev), .i_ext_pin(ext),
		.i_per_pin_change_flags(pins), .i_serial_rx_ready(rx),
		.i_serial_tx_empty(tx), .o_core_irq_req(irq), .o_wake_req(wake));
	pif_periph_model #(.PIN_FLAGS(12)) periph (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_fire(fire), .i_pin_set(pset),
		.i_pin_clr(pclr), .i_serial_cmd(scmd), .o_events(ev),
		.o_pin_flags(pins), .o_rx_ready(rx), .o_tx_empty(tx));

	// 25 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	// ============================================================
	// Shared tasks
	task automatic check(input string name, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clock);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge i_clock);
		wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [11:0] a, input logic [7:0] e,
		input string name);
		@(posedge i_clock);
		rd   <= 1'b1;
		addr <= a;
		@(posedge i_clock);
		rd <= 1'b0;
		@(negedge i_clock);
		check(name, rdata, e);
	endtask

	task automatic irq_is(input logic e);
		@(negedge i_clock);
		check("core_irq", {7'h00, irq}, {7'h00, e});
	endtask

	// One-cycle command to the peripheral model
	task automatic poke(input logic [9:0] f, input logic [11:0] s, c,
		input logic [3:0] q);
		@(posedge i_clock);
		fire <= f;
		pset <= s;
		pclr <= c;
		scmd <= q;
		@(posedge i_clock);
		fire <= 10'h000;
		pset <= 12'h000;
		pclr <= 12'h000;
		scmd <= 4'h0;
	endtask

	task automatic give_verdict;
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		give_verdict();
	end

	// ============================================================
	// Scenarios
	initial begin
		{wr, rd, ext, addr, wdata, fire, pset, pclr, scmd} = '0;
		err_total = 0;
		compares  = 0;
		i_sys_rst = 1'b1;
		repeat (3) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		// Reset values, unmapped place
		reg_rd(PIF_OFS_CONTROL, 8'h01, "control");
		reg_rd(PIF_OFS_REQ0, 8'h00, "req0");
		reg_rd(PIF_OFS_REQ1, 8'h08, "req1");
		reg_rd(PIF_OFS_EN2, 8'h00, "en2");
		reg_wr(12'h700, 8'hff);
		reg_rd(12'h700, 8'h00, "unmapped");
		// Every event with all enables and gates off still sets its flag
		poke(10'h3ff, 12'h000, 12'h000, 4'h0);
		reg_rd(PIF_OFS_REQ0, 8'h20, "req0");
		reg_rd(PIF_OFS_REQ1, 8'hef, "req1");
		reg_rd(PIF_OFS_REQ2, 8'he0, "req2");
		irq_is(1'b0);
		check("wake", {7'h00, wake}, 8'h00);
		// Clearing by zero writes; live bits ignore the write
		reg_wr(PIF_OFS_REQ1, 8'h18);
		reg_rd(PIF_OFS_REQ1, 8'h08, "req1");
		reg_wr(PIF_OFS_REQ0, 8'hff);
		reg_rd(PIF_OFS_REQ0, 8'h21, "req0");
		reg_wr(PIF_OFS_REQ0, 8'h00);
		reg_wr(PIF_OFS_REQ2, 8'h00);
		reg_rd(PIF_OFS_REQ2, 8'h00, "req2");
		// Event in the same cycle as a clearing write wins
		@(posedge i_clock);
		{wr, addr, wdata, fire} <= {1'b1, PIF_OFS_REQ1, 8'h00, 10'h080};
		@(posedge i_clock);
		{wr, fire} <= '0;
		reg_rd(PIF_OFS_REQ1, 8'h48, "req1");
		reg_wr(PIF_OFS_REQ1, 8'h00);
		// First group needs only the global enable; flags cleared last
		reg_wr(PIF_OFS_EN0, 8'h20);
		reg_wr(PIF_OFS_CONTROL, 8'h81);
		poke(10'h200, 12'h000, 12'h000, 4'h0);
		irq_is(1'b1);
		reg_wr(PIF_OFS_CONTROL, 8'h41);
		irq_is(1'b0);
		check("wake", {7'h00, wake}, 8'h01);
		reg_wr(PIF_OFS_REQ0, 8'h00);
		// Second group held off by the group gate
		reg_wr(PIF_OFS_EN1, 8'h80);
		reg_wr(PIF_OFS_CONTROL, 8'h81);
		poke(10'h100, 12'h000, 12'h000, 4'h0);
		irq_is(1'b0);
		reg_wr(PIF_OFS_CONTROL, 8'hc1);
		irq_is(1'b1);
		reg_wr(PIF_OFS_REQ1, 8'h00);
		irq_is(1'b0);
		// Each third enable bit alone, with and without the group gate
		for (i = 5; i < 8; i++) begin
			reg_wr(PIF_OFS_EN2, 8'(1 << i));
			reg_wr(PIF_OFS_REQ2, 8'he0 & ~8'(1 << i));
			irq_is(1'b0);
			reg_wr(PIF_OFS_REQ2, 8'(1 << i));
			irq_is(1'b1);
			reg_wr(PIF_OFS_CONTROL, 8'h81);
			irq_is(1'b0);
			reg_wr(PIF_OFS_CONTROL, 8'hc1);
			reg_wr(PIF_OFS_REQ2, 8'h00);
		end
		reg_wr(PIF_OFS_EN2, 8'hff);
		reg_rd(PIF_OFS_EN2, 8'he0, "en2");
		reg_wr(PIF_OFS_CONTROL, 8'h01);
		// Pin change summary clears only with the last pin flag
		poke(10'h000, 12'h801, 12'h000, 4'h0);
		reg_rd(PIF_OFS_REQ0, 8'h10, "req0");
		poke(10'h000, 12'h000, 12'h001, 4'h0);
		reg_wr(PIF_OFS_REQ0, 8'h00);
		reg_rd(PIF_OFS_REQ0, 8'h10, "req0");
		poke(10'h000, 12'h000, 12'h800, 4'h0);
		reg_rd(PIF_OFS_REQ0, 8'h00, "req0");
		// Receive ready and transmit empty follow the buffers
		poke(10'h000, 12'h000, 12'h000, 4'ha);
		reg_rd(PIF_OFS_REQ1, 8'h10, "req1");
		poke(10'h000, 12'h000, 12'h000, 4'h5);
		reg_rd(PIF_OFS_REQ1, 8'h08, "req1");
		// External edge, rising then falling select
		@(posedge i_clock);
		ext <= 1'b1;
		reg_rd(PIF_OFS_REQ0, 8'h01, "req0");
		reg_wr(PIF_OFS_CONTROL, 8'h00);
		reg_wr(PIF_OFS_REQ0, 8'h00);
		reg_rd(PIF_OFS_REQ0, 8'h00, "req0");
		@(posedge i_clock);
		ext <= 1'b0;
		reg_rd(PIF_OFS_REQ0, 8'h01, "req0");
		give_verdict();
	end
endmodule
`default_nettype wire
